// File: hw/ccd_detect.sv
// Current-detect window: counts threshold exceedances per measurement length
`timescale 1ns/1ps
module ccd_detect (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_enable,
    input wire logic i_all_channels,
    input wire logic [2:0] i_hit_code,
    input wire logic [2:0] i_len_code,
    input wire logic [15:0] i_thr_upper,
    // Samples
    input wire logic i_conv_valid,
    input wire logic [ccd_pkg::CCD_NCH*ccd_pkg::CCD_SW-1:0] i_samples,
    // Events
    output logic o_detect_pulse,
    output logic o_window_pulse
);
    import ccd_pkg::*;

    logic [CCD_LEN_CW-1:0] len_cnt_r, len_cnt_nxt;
    logic [CCD_HIT_CW:0] hit_cnt_r, hit_cnt_nxt;
    logic fired_r, fired_nxt;
    logic det_r, det_nxt;
    logic win_r, win_nxt;
    logic [CCD_NCH-1:0] over;
    logic hit;
    logic [CCD_LEN_CW-1:0] win_len;
    logic [CCD_HIT_CW:0] need;

    function automatic logic [CCD_LEN_CW-1:0] len_of(input logic [2:0] c);
        case (c) // [RULE7]
            3'h0: len_of = 12'h080;
            3'h1: len_of = 12'h100;
            3'h2: len_of = 12'h200;
            3'h3: len_of = 12'h300;
            3'h4: len_of = 12'h500;
            3'h5: len_of = 12'h700;
            3'h6: len_of = 12'hA00;
            default: len_of = 12'hE00;
        endcase
    endfunction : len_of

    // Magnitude compare per channel against the upper threshold bits
    genvar g;
    generate
        for (g = 0; g < CCD_NCH; g++) begin : g_cmp
            logic [CCD_SW-1:0] s;
            logic [CCD_SW-1:0] mag;
            assign s = i_samples[g*CCD_SW +: CCD_SW];
            assign mag = s[CCD_SW-1] ? (~s + 1'b1) : s;
            assign over[g] = mag[CCD_SW-1 -: 16] > i_thr_upper; // [RULE8]
        end
    endgenerate

    always_comb begin
        hit = i_all_channels ? (&over) : (|over); // [RULE5]
        win_len = len_of(i_len_code);
        need = (CCD_HIT_CW+1)'(1) << i_hit_code; // [RULE6]
        len_cnt_nxt = len_cnt_r;
        hit_cnt_nxt = hit_cnt_r;
        fired_nxt = fired_r;
        det_nxt = 1'b0;
        win_nxt = 1'b0;
        if (!i_enable) begin
            len_cnt_nxt = '0;
            hit_cnt_nxt = '0;
            fired_nxt = 1'b0;
        end else if (i_conv_valid) begin
            if (hit && !fired_r) begin
                hit_cnt_nxt = hit_cnt_r + 1'b1; // [RULE9]
                if (hit_cnt_r + 1'b1 >= need) begin
                    det_nxt = 1'b1; // [RULE9]
                    fired_nxt = 1'b1;
                end
            end
            if (len_cnt_r + 1'b1 >= win_len) begin
                len_cnt_nxt = '0; // [RULE7]
                hit_cnt_nxt = '0;
                fired_nxt = 1'b0;
                win_nxt = 1'b1;
            end else begin
                len_cnt_nxt = len_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            len_cnt_r <= '0;
            hit_cnt_r <= '0;
            fired_r <= 1'b0;
            det_r <= 1'b0;
            win_r <= 1'b0;
        end else begin
            len_cnt_r <= len_cnt_nxt;
            hit_cnt_r <= hit_cnt_nxt;
            fired_r <= fired_nxt;
            det_r <= det_nxt;
            win_r <= win_nxt;
        end
    end

    assign o_detect_pulse = det_r;
    assign o_window_pulse = win_r;
endmodule : ccd_detect

// File: hw/ccd_pkg.sv
// Package: register map, field layout and timing constants for chop/detect
package ccd_pkg;
    localparam int CCD_AW = 4;
    localparam int CCD_DW = 32;
    localparam int CCD_NCH = 4;
    localparam int CCD_SW = 24;
    // Register indices (byte address = index * 4)
    localparam logic [CCD_AW-1:0] CCD_IDX_CFG = 4'h6;
    localparam logic [CCD_AW-1:0] CCD_IDX_THR_UP = 4'h7;
    localparam logic [CCD_AW-1:0] CCD_IDX_STATUS = 4'hC;
    localparam logic [CCD_AW-1:0] CCD_IDX_MASK = 4'hD;
    localparam logic [CCD_AW-1:0] CCD_IDX_STATE = 4'hE;
    // Configuration word layout
    localparam int CCD_F_RSV_LO = 13;
    localparam int CCD_F_DLY_LO = 9;
    localparam int CCD_F_CHOP_EN = 8;
    localparam int CCD_F_ALLCH = 7;
    localparam int CCD_F_NUM_LO = 4;
    localparam int CCD_F_LEN_LO = 1;
    localparam int CCD_F_DET_EN = 0;
    localparam logic [15:0] CCD_CFG_RST = 16'h0600;
    localparam logic [15:0] CCD_CFG_WMASK = 16'h1FFF;
    localparam logic [15:0] CCD_THR_RST = 16'h0000;
    // Interrupt status bits
    localparam int CCD_NEV = 3;
    localparam int CCD_EV_DETECT = 0;
    localparam int CCD_EV_WINDOW = 1;
    localparam int CCD_EV_SETTLE = 2;
    // Counter widths
    localparam int CCD_DLY_CW = 17;
    localparam int CCD_LEN_CW = 12;
    localparam int CCD_HIT_CW = 8;
endpackage : ccd_pkg

// File: hw/ccd_settle.sv
// Chop settling delay counter, counted in modulator clock enables
`timescale 1ns/1ps
module ccd_settle (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_enable,
    input wire logic i_mod_tick,
    input wire logic [3:0] i_delay_code,
    // Status
    output logic o_settled,
    output logic o_done_pulse
);
    import ccd_pkg::*;

    logic [ccd_pkg::CCD_DLY_CW-1:0] cnt_r, cnt_nxt;
    logic settled_r, settled_nxt;
    logic done_r, done_nxt;
    logic [ccd_pkg::CCD_DLY_CW-1:0] target;

    always_comb begin
        // Code n gives 2^(n+1) periods
        target = ccd_pkg::CCD_DLY_CW'(2) << i_delay_code; // [RULE2]
        cnt_nxt = cnt_r;
        settled_nxt = settled_r;
        done_nxt = 1'b0;
        if (!i_enable) begin
            cnt_nxt = '0;
            settled_nxt = 1'b0;
        end else if (!settled_r && i_mod_tick) begin
            if (cnt_r + 1'b1 >= target) begin
                settled_nxt = 1'b1; // [RULE2]
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cnt_r <= '0;
            settled_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            settled_r <= settled_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_settled = settled_r;
    assign o_done_pulse = done_r;
endmodule : ccd_settle

// File: hw/ccd_top.sv
// Chop and current-detect configuration bank with Avalon-MM slave
// Notes on behaviour
// RULE1: Software writes zeros to config bits 15:13; hardware stores zero.
// RULE2: With chopping on, wait 2^(code+1) modulator periods before measuring.
// RULE3: Settling delay code resets to 0011b, sixteen modulator periods.
// RULE4: Bit 8 enables chopping, bit 0 enables current detect; both reset off.
// RULE5: Channel select clear: any channel triggers; set: all channels at once.
// RULE6: Detection needs 2^code exceedances, one to 128; reset code gives one.
// RULE7: Window length codes select 128 to 3584 conversion periods; reset 128.
// RULE8: Threshold upper sixteen bits live in their own word, reset zero.
// RULE9: Count exceedances per window; flag detection when count hits target.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module ccd_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Avalon-MM slave
    input wire logic [ccd_pkg::CCD_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [ccd_pkg::CCD_DW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [ccd_pkg::CCD_DW-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    // Converter timing and samples
    input wire logic i_mod_tick,
    input wire logic i_conv_valid,
    input wire logic [ccd_pkg::CCD_NCH*ccd_pkg::CCD_SW-1:0] i_samples,
    // Block outputs
    output logic o_chop_active,
    output logic o_measure_go,
    output logic o_detect_active,
    output logic o_detect,
    output logic o_irq
);
    import ccd_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    typedef enum logic [1:0] {CCD_BUS_IDLE, CCD_BUS_ACK} ccd_bus_e;

    ccd_bus_e bus_r, bus_nxt;
    logic [15:0] cfg_r, cfg_nxt;
    logic [15:0] thr_r, thr_nxt;
    logic [CCD_NEV-1:0] sts_r, sts_nxt;
    logic [CCD_NEV-1:0] msk_r, msk_nxt;
    logic [CCD_DW-1:0] rdata_r, rdata_nxt;
    logic [1:0] resp_r, resp_nxt;
    logic wait_r, wait_nxt;
    logic irq_r, irq_nxt;
    logic chop_r, chop_nxt;
    logic go_r, go_nxt;
    logic det_on_r, det_on_nxt;
    logic det_r, det_nxt;

    logic settled;
    logic settle_done;
    logic det_pulse;
    logic win_pulse;
    logic [CCD_NEV-1:0] events;
    logic wr_take;
    logic rd_take;
    logic [15:0] wmask;

    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Byte enables turn into a 16-bit write mask
    function automatic logic [15:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    function automatic logic known(input logic [CCD_AW-1:0] a);
        if (a == CCD_IDX_CFG) begin
            known = 1'b1;
        end else if (a == CCD_IDX_THR_UP) begin
            known = 1'b1;
        end else if (a == CCD_IDX_STATUS) begin
            known = 1'b1;
        end else if (a == CCD_IDX_MASK) begin
            known = 1'b1;
        end else if (a == CCD_IDX_STATE) begin
            known = 1'b1;
        end else begin
            known = 1'b0;
        end
    endfunction : known

    // ****************************************************************
    // Worker modules
    // ****************************************************************
    ccd_settle u_settle (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(cfg_r[CCD_F_CHOP_EN]),
        .i_mod_tick(i_mod_tick),
        .i_delay_code(cfg_r[CCD_F_DLY_LO +: 4]),
        .o_settled(settled),
        .o_done_pulse(settle_done)
    );

    ccd_detect u_detect (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_enable(cfg_r[CCD_F_DET_EN]),
        .i_all_channels(cfg_r[CCD_F_ALLCH]),
        .i_hit_code(cfg_r[CCD_F_NUM_LO +: 3]),
        .i_len_code(cfg_r[CCD_F_LEN_LO +: 3]),
        .i_thr_upper(thr_r),
        .i_conv_valid(i_conv_valid),
        .i_samples(i_samples),
        .o_detect_pulse(det_pulse),
        .o_window_pulse(win_pulse)
    );

    // ****************************************************************
    // Bus handshake: take, then one answer cycle
    // ****************************************************************
    // The request is taken once, at the edge that finds the slave idle;
    // waitrequest then drops for one cycle, so every access costs two.
    always_comb begin
        bus_nxt = bus_r;
        wait_nxt = 1'b1;
        resp_nxt = resp_r;
        wr_take = 1'b0;
        rd_take = 1'b0;
        case (bus_r)
            CCD_BUS_IDLE: begin
                if (i_avs_write || i_avs_read) begin
                    wr_take = i_avs_write;
                    rd_take = i_avs_read;
                    wait_nxt = 1'b0;
                    bus_nxt = CCD_BUS_ACK;
                    resp_nxt = known(i_avs_address) ? RESP_OK : RESP_SLVERR;
                end
            end
            default: begin
                // Request still held here; it is not taken twice
                bus_nxt = CCD_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            bus_r <= CCD_BUS_IDLE;
            wait_r <= 1'b1;
            resp_r <= RESP_OK;
        end else begin
            bus_r <= bus_nxt;
            wait_r <= wait_nxt;
            resp_r <= resp_nxt;
        end
    end

    // ****************************************************************
    // Configuration and threshold words
    // ****************************************************************
    // Lanes 2 and 3 carry nothing: each word is sixteen bits wide.
    // A write with both lanes off changes nothing but is still answered.
    always_comb begin
        wmask = be_mask(i_avs_byteenable);
        cfg_nxt = cfg_r;
        thr_nxt = thr_r;
        if (wr_take) begin
            if (i_avs_address == CCD_IDX_CFG) begin
                // Reserved top bits are never stored
                cfg_nxt = (cfg_r & ~(wmask & CCD_CFG_WMASK)) // [RULE1]
                    | (i_avs_writedata[15:0] & wmask & CCD_CFG_WMASK);
            end else if (i_avs_address == CCD_IDX_THR_UP) begin
                thr_nxt = (thr_r & ~wmask)
                    | (i_avs_writedata[15:0] & wmask); // [RULE8]
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cfg_r <= CCD_CFG_RST; // [RULE3][RULE4][RULE5][RULE6][RULE7]
            thr_r <= CCD_THR_RST; // [RULE8]
        end else begin
            cfg_r <= cfg_nxt;
            thr_r <= thr_nxt;
        end
    end

    // ****************************************************************
    // Event status, mask and interrupt
    // ****************************************************************
    // Writing a one clears a bit; an event in the same cycle keeps it set,
    // so no event is lost to a clear that raced it.
    always_comb begin
        events = '0;
        events[CCD_EV_DETECT] = det_pulse;
        events[CCD_EV_WINDOW] = win_pulse;
        events[CCD_EV_SETTLE] = settle_done;
        sts_nxt = sts_r;
        msk_nxt = msk_r;
        if (wr_take && i_avs_byteenable[0]) begin
            if (i_avs_address == CCD_IDX_STATUS) begin
                sts_nxt = sts_r & ~i_avs_writedata[CCD_NEV-1:0];
            end else if (i_avs_address == CCD_IDX_MASK) begin
                msk_nxt = i_avs_writedata[CCD_NEV-1:0];
            end
        end
        // Set beats clear in the same cycle
        sts_nxt = sts_nxt | events;
        // The interrupt follows the next status, so it needs no extra cycle
        irq_nxt = |(sts_nxt & msk_nxt);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sts_r <= '0;
            msk_r <= '0;
            irq_r <= 1'b0;
        end else begin
            sts_r <= sts_nxt;
            msk_r <= msk_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************************************
    // Read data, captured at the take edge
    // ****************************************************************
    // Values stand until the next read; unmapped indices read as zero.
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_take) begin
            rdata_nxt = '0;
            if (i_avs_address == CCD_IDX_CFG) begin
                rdata_nxt[15:0] = cfg_r;
            end else if (i_avs_address == CCD_IDX_THR_UP) begin
                rdata_nxt[15:0] = thr_r;
            end else if (i_avs_address == CCD_IDX_STATUS) begin
                rdata_nxt[CCD_NEV-1:0] = sts_r;
            end else if (i_avs_address == CCD_IDX_MASK) begin
                rdata_nxt[CCD_NEV-1:0] = msk_r;
            end else if (i_avs_address == CCD_IDX_STATE) begin
                rdata_nxt[3:0] = {det_r, det_on_r, settled, chop_r};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Block status outputs
    // ****************************************************************
    // Measurement may start only once chopping has settled.
    always_comb begin
        chop_nxt = cfg_r[CCD_F_CHOP_EN]; // [RULE4]
        go_nxt = cfg_r[CCD_F_CHOP_EN] && settled; // [RULE2]
        det_on_nxt = cfg_r[CCD_F_DET_EN]; // [RULE4]
        // Detection flag holds until window restart or disable
        if (!cfg_r[CCD_F_DET_EN]) begin
            det_nxt = 1'b0;
        end else if (det_pulse) begin
            det_nxt = 1'b1; // [RULE9]
        end else if (win_pulse) begin
            det_nxt = 1'b0;
        end else begin
            det_nxt = det_r;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            chop_r <= 1'b0;
            go_r <= 1'b0;
            det_on_r <= 1'b0;
            det_r <= 1'b0;
        end else begin
            chop_r <= chop_nxt;
            go_r <= go_nxt;
            det_on_r <= det_on_nxt;
            det_r <= det_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_avs_response = resp_r;
    assign o_irq = irq_r;
    assign o_chop_active = chop_r;
    assign o_measure_go = go_r;
    assign o_detect_active = det_on_r;
    assign o_detect = det_r;
endmodule : ccd_top

// File: tb/ccd_checker.sv
// Port assertions for the chop and current-detect configuration bank
`timescale 1ns/1ps
module ccd_checker
    import ccd_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register bus
    input wire logic [ccd_pkg::CCD_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [ccd_pkg::CCD_DW-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [ccd_pkg::CCD_DW-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    // Block
    input wire logic i_mod_tick,
    input wire logic i_conv_valid,
    input wire logic o_chop_active,
    input wire logic o_measure_go,
    input wire logic o_detect_active,
    input wire logic o_detect
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic mapped;
    assign mapped = i_avs_address inside {CCD_IDX_CFG, CCD_IDX_THR_UP,
        CCD_IDX_STATUS, CCD_IDX_MASK, CCD_IDX_STATE};
    sequence s_ack;
        !o_avs_waitrequest && (i_avs_read || i_avs_write);
    endsequence
    sequence s_cfg_wr;
        s_ack ##0 (i_avs_write && i_avs_address == CCD_IDX_CFG);
    endsequence
    AST_ACK_ONE: assert property ($fell(o_avs_waitrequest) |=>
        o_avs_waitrequest) else $error("waitrequest low too long");
    AST_ACK_REQ: assert property (!o_avs_waitrequest |->
        (i_avs_read || i_avs_write)) else $error("answer without request");
    AST_UNMAPPED: assert property (s_ack ##0 !mapped |->
        o_avs_response == 2'b10 && (i_avs_write || o_avs_readdata == '0))
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (s_ack ##0 mapped |->
        o_avs_response == 2'b00) else $error("mapped access refused");
    AST_CFG_RSV: assert property (s_ack ##0 (i_avs_read &&
        i_avs_address == CCD_IDX_CFG) |-> o_avs_readdata[15:13] == 3'b000)
        else $error("reserved config bits read nonzero");
    AST_CHOP_EN: assert property (s_cfg_wr ##0 i_avs_byteenable[1] |=>
        o_chop_active == $past(i_avs_writedata[8]))
        else $error("chop enable not applied");
    AST_DET_EN: assert property (s_cfg_wr ##0 i_avs_byteenable[0] |=>
        o_detect_active == $past(i_avs_writedata[0]))
        else $error("detect enable not applied");
    AST_GO_CAUSE: assert property ($rose(o_measure_go) |->
        $past(i_mod_tick, 2)) else $error("measure start without tick");
    AST_GO_OFF: assert property (!o_chop_active [*2] |->
        !o_measure_go) else $error("measure start with chop off");
    AST_DET_CAUSE: assert property ($rose(o_detect) |->
        $past(i_conv_valid, 2)) else $error("detect without conversion");
    AST_DET_OFF: assert property (!o_detect_active [*2] |->
        !o_detect) else $error("detect with mode off");
endmodule : ccd_checker

bind ccd_top ccd_checker u_chk (.i_sys_clk, .i_reset, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_mod_tick,
    .i_conv_valid, .o_chop_active, .o_measure_go, .o_detect_active,
    .o_detect);

// File: tb/tb_ccd_top.sv
// Self-checking bench for the chop and current-detect configuration bank
`timescale 1ns/1ps
module tb_ccd_top;
    import ccd_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [CCD_AW-1:0] i_avs_address = '0;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [CCD_DW-1:0] i_avs_writedata = '0;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [CCD_DW-1:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic [1:0] o_avs_response;
    logic i_mod_tick = 1'b0;
    logic i_conv_valid = 1'b0;
    logic [CCD_NCH*CCD_SW-1:0] i_samples = '0;
    logic o_chop_active, o_measure_go, o_detect_active, o_detect, o_irq;
    int n_errors = 0;
    int comparisons = 0;
    integer seed = 55;
    logic [31:0] rd, r;
    logic [1:0] rsp;
    logic [15:0] v, w;
    logic [3:0] h;
    logic [95:0] s;
    int cnt;

    always #10 i_sys_clk = ~i_sys_clk;

    ccd_top u_dut (.i_sys_clk, .i_reset, .i_avs_address, .i_avs_read,
        .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .o_avs_response, .i_mod_tick, .i_conv_valid,
        .i_samples, .o_chop_active, .o_measure_go, .o_detect_active,
        .o_detect, .o_irq);

    // *****
    // Expectation and stimulus helpers
    // *****
    function automatic int win_len(input int c);
        int t [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
        return t[c];
    endfunction : win_len

    function automatic int hit_of(input logic all, input logic [3:0] x);
        return int'(all ? &x : |x);
    endfunction : hit_of

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [3:0] a,
                       input logic [15:0] d, input logic [3:0] be);
        int t;
        t = 0;
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_write <= we;
        i_avs_read <= ~we;
        i_avs_writedata <= {16'h0000, d};
        i_avs_byteenable <= be;
        do begin
            @(posedge i_sys_clk);
            t++;
        end while (o_avs_waitrequest !== 1'b0);
        chk("bus_cycles", 32'd2, 32'(t));
        rd = o_avs_readdata;
        rsp = o_avs_response;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask : wr

    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 4'hF);
        chk(nm, {16'h0000, e}, rd);
    endtask : rchk

    // One strobe, then settle two cycles so registered results show
    task automatic pulse(input logic conv, input logic [95:0] d);
        @(posedge i_sys_clk);
        i_conv_valid <= conv;
        i_mod_tick <= ~conv;
        i_samples <= d;
        @(posedge i_sys_clk);
        i_conv_valid <= 1'b0;
        i_mod_tick <= 1'b0;
        i_samples <= ~d;
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask : pulse

    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // *****
    // Test sequence
    // *****
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rchk("cfg_rst", CCD_IDX_CFG, 16'h0600);
        rchk("thr_rst", CCD_IDX_THR_UP, 16'h0000);
        rchk("status_rst", CCD_IDX_STATUS, 16'h0000);
        bus(1'b1, 4'h5, 16'hFFFF, 4'hF);
        rchk("unmapped", 4'h5, 16'h0000);
        chk("unmapped_resp", 32'h2, 32'(rsp));
        repeat (8) begin
            v = $random(seed);
            w = $random(seed);
            v[15:13] = 3'b000;
            wr(CCD_IDX_CFG, v);
            rchk("cfg", CCD_IDX_CFG, v);
            bus(1'b1, CCD_IDX_CFG, {3'b000, w[12:0]}, 4'h1);
            rchk("cfg_lane", CCD_IDX_CFG, {v[15:8], w[7:0]});
            wr(CCD_IDX_THR_UP, w);
            rchk("thr", CCD_IDX_THR_UP, w);
        end
        for (int c = 0; c < 5; c++) begin
            wr(CCD_IDX_CFG, 16'h0000);
            repeat (3) pulse(1'b0, '0);
            wr(CCD_IDX_STATUS, 16'h0007);
            wr(CCD_IDX_CFG, 16'(c * 512 + 256));
            for (int n = 1; n <= (2 << c); n++) begin
                pulse(1'b0, '0);
                chk("measure_go", 32'(n == (2 << c)), 32'(o_measure_go));
            end
            chk("chop_active", 32'h1, 32'(o_chop_active));
            rchk("settle_sts", CCD_IDX_STATUS, 16'h0004);
            rchk("state", CCD_IDX_STATE, 16'h0003);
        end
        wr(CCD_IDX_THR_UP, 16'h0010);
        for (int c = 0; c < 8; c++) begin
            wr(CCD_IDX_CFG, 16'h0000);
            wr(CCD_IDX_CFG, 16'(c % 2 * 128 + c / 2 * 16 + 1));
            wr(CCD_IDX_STATUS, 16'h0007);
            cnt = 0;
            repeat (40) begin
                r = $random(seed);
                h = (c % 2 == 1 && r[4]) ? 4'hF : r[3:0];
                for (int k = 0; k < 4; k++) begin
                    s[k*24 +: 24] = h[k] ? (r[8+k] ? 24'hFFEF00 : 24'h001100)
                        : (r[8+k] ? 24'hFFF000 : 24'h001000);
                end
                pulse(1'b1, s);
                cnt += hit_of(c % 2 == 1, h);
                chk("detect", 32'(cnt >= (1 << (c / 2))), 32'(o_detect));
            end
            chk("detect_active", 32'h1, 32'(o_detect_active));
            v = 16'(cnt >= (1 << (c / 2)));
            rchk("det_sts", CCD_IDX_STATUS, v);
        end
        wr(CCD_IDX_THR_UP, 16'hFFFF);
        for (int c = 0; c < 8; c++) begin
            wr(CCD_IDX_MASK, (c == 7) ? 16'h0000 : 16'h0002);
            wr(CCD_IDX_CFG, 16'h0000);
            wr(CCD_IDX_STATUS, 16'h0007);
            wr(CCD_IDX_CFG, 16'(c * 2 + 1));
            repeat (win_len(c) - 1) pulse(1'b1, '0);
            rchk("window_early", CCD_IDX_STATUS, 16'h0000);
            pulse(1'b1, '0);
            rchk("window_end", CCD_IDX_STATUS, 16'h0002);
            chk("irq_set", 32'(c != 7), 32'(o_irq));
            wr(CCD_IDX_STATUS, 16'h0002);
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk("irq_clear", 32'h0, 32'(o_irq));
        end
        report_and_stop();
    end

    initial begin
        repeat (95000) @(posedge i_sys_clk);
        n_errors++;
        report_and_stop();
    end
endmodule : tb_ccd_top
